// ### hdl/mgmt_pkg.sv
/*
 * Constants shared by the management serial port and the register bank:
 * frame layout, register offsets, field positions, reset values and masks.
 * Assumes a 16-bit register file addressed by a 5-bit register number.
 */
package mgmt_pkg;

    localparam int unsigned DATA_W      = 16;
    localparam int unsigned ADDR_W      = 5;
    localparam int unsigned PREAMBLE_LEN = 32;
    localparam int unsigned CNT_W       = 6;
    localparam int unsigned OP_BITS     = 2;
    localparam int unsigned ADDR_BITS   = 2 * ADDR_W;
    localparam int unsigned TA_BITS     = 2;

    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // Register numbers
    localparam logic [4:0] REG_ID_LOW    = 5'h03;
    localparam logic [4:0] REG_ADVERTISE = 5'h04;
    localparam logic [4:0] REG_PARTNER   = 5'h05;
    localparam logic [4:0] REG_LINE_CFG1 = 5'h10;

    // Identifier fields
    localparam int unsigned ID_VENDOR_LSB = 10;
    localparam int unsigned ID_MODEL_LSB  = 4;

    // Advertisement / partner fields
    localparam int unsigned NEXT_PAGE_BIT   = 15;
    localparam int unsigned ACK_BIT         = 14;
    localparam int unsigned REMOTE_FAULT_BIT = 13;
    localparam logic [15:0] ADV_RESET      = 16'h01E1;
    localparam logic [15:0] ADV_WR_MASK    = 16'hBFFF;
    localparam logic [15:0] PARTNER_RESET  = 16'h0000;
    localparam logic [15:0] PARTNER_MASK   = 16'hE3E1;

    // Line configuration one fields
    localparam int unsigned CFG_LINK_OFF   = 15;
    localparam int unsigned CFG_TX_OFF     = 14;
    localparam int unsigned CFG_TX_PDN     = 13;
    localparam int unsigned CFG_LOOP_OFF   = 12;
    localparam int unsigned CFG_CODER_SKIP = 11;
    localparam int unsigned CFG_SCR_SKIP   = 10;
    localparam int unsigned CFG_EQ_SEL     = 8;
    localparam int unsigned CFG_CABLE      = 7;
    localparam int unsigned CFG_RX_LEVEL   = 6;
    localparam int unsigned CFG_TLVL_LSB   = 2;
    localparam int unsigned CFG_TLVL_MSB   = 5;
    localparam int unsigned CFG_EDGE_MSB   = 1;
    localparam logic [15:0] CFG_RESET      = 16'h0022;
    localparam logic [15:0] CFG_WR_MASK    = 16'hFFFF;

endpackage

// ### hdl/mgmt_if.sv
/*
 * Register access carrier between the management serial port and the
 * register bank. Read data is combinational from the bank; write is a
 * one-cycle strobe with address and data.
 */
`timescale 1ns/1ps
interface mgmt_if;
    logic [mgmt_pkg::ADDR_W-1:0] rd_addr;
    logic [mgmt_pkg::DATA_W-1:0] rd_data;
    logic                        wr_en;
    logic [mgmt_pkg::ADDR_W-1:0] wr_addr;
    logic [mgmt_pkg::DATA_W-1:0] wr_data;

    modport port_side (output rd_addr, input rd_data, output wr_en, output wr_addr,
                       output wr_data);
    modport bank_side (input rd_addr, output rd_data, input wr_en, input wr_addr,
                       input wr_data);
endinterface

// ### hdl/mgmt_serial_port.sv
/*
 * Serial management frame engine: preamble, start, opcode, device and
 * register address, turnaround and 16 data bits, most significant first.
 * Assumes mdc is far slower than sys_clk (at least 4 sys_clk per half).
 */
`timescale 1ns/1ps
module mgmt_serial_port #(
    parameter logic [4:0] PHY_ADDR = 5'h00
) (
    input  wire logic sys_clk,   // System clock
    input  wire logic rst,       // Synchronous reset
    input  wire logic mdc,       // Management clock pin
    input  wire logic mdio_in,   // Data pin level
    output logic      mdio_out,  // Data pin drive value
    output logic      mdio_oe,   // Data pin drive enable
    mgmt_if.port_side bus        // Register access
);
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ST1  = 6'h02,
        S_OP   = 6'h04,
        S_ADDR = 6'h08,
        S_TA   = 6'h10,
        S_DATA = 6'h20
    } state_t;

    typedef struct packed {
        state_t                      state;
        logic [mgmt_pkg::CNT_W-1:0]  cnt;
        logic [mgmt_pkg::DATA_W-1:0] sh;
        logic                        is_read;
        logic                        match;
        logic [mgmt_pkg::ADDR_W-1:0] addr;
        logic                        mdc_s1;
        logic                        mdc_s2;
        logic                        mdc_prev;
        logic                        dio_s1;
        logic                        dio_s2;
        logic                        oe;
        logic                        dout;
        logic                        wr_en;
    } port_state_t;

    localparam port_state_t RESET_STATE = '{state: S_IDLE, default: '0};

    port_state_t q;
    port_state_t d;
    logic        rise;
    logic        fall;
    logic [5:0]  cnt_inc;

    assign rise    = q.mdc_s2 & ~q.mdc_prev;
    assign fall    = ~q.mdc_s2 & q.mdc_prev;
    assign cnt_inc = q.cnt + 6'h01;

    always_comb begin
        d          = q;
        d.mdc_s1   = mdc;
        d.mdc_s2   = q.mdc_s1;
        d.mdc_prev = q.mdc_s2;
        d.dio_s1   = mdio_in;
        d.dio_s2   = q.dio_s1;
        d.wr_en    = 1'b0;
        if (rise) begin
            unique case (q.state)
                S_IDLE: begin
                    if (q.dio_s2) begin
                        if (q.cnt < mgmt_pkg::CNT_W'(mgmt_pkg::PREAMBLE_LEN)) begin
                            d.cnt = cnt_inc;
                        end
                    end else if (q.cnt == mgmt_pkg::CNT_W'(mgmt_pkg::PREAMBLE_LEN)) begin
                        d.state = S_ST1;
                        d.cnt   = '0;
                    end else begin
                        d.cnt = '0;
                    end
                end
                S_ST1: begin
                    d.state = q.dio_s2 ? S_OP : S_IDLE;
                end
                S_OP: begin
                    d.sh  = {q.sh[14:0], q.dio_s2};
                    d.cnt = cnt_inc;
                    if (cnt_inc == mgmt_pkg::CNT_W'(mgmt_pkg::OP_BITS)) begin
                        d.cnt     = '0;
                        d.is_read = ({q.sh[0], q.dio_s2} == mgmt_pkg::OP_READ);
                        if ({q.sh[0], q.dio_s2} == mgmt_pkg::OP_READ ||
                            {q.sh[0], q.dio_s2} == mgmt_pkg::OP_WRITE) begin
                            d.state = S_ADDR;
                        end else begin
                            d.state = S_IDLE;
                        end
                    end
                end
                S_ADDR: begin
                    d.sh  = {q.sh[14:0], q.dio_s2};
                    d.cnt = cnt_inc;
                    if (cnt_inc == mgmt_pkg::CNT_W'(mgmt_pkg::ADDR_BITS)) begin
                        d.cnt   = '0;
                        d.match = (q.sh[8:4] == PHY_ADDR);
                        d.addr  = {q.sh[3:0], q.dio_s2};
                        d.state = S_TA;
                    end
                end
                S_TA: begin
                    d.cnt = cnt_inc;
                    if (cnt_inc == mgmt_pkg::CNT_W'(mgmt_pkg::TA_BITS)) begin
                        d.cnt   = '0;
                        d.state = S_DATA;
                        d.sh    = bus.rd_data;
                    end
                end
                S_DATA: begin
                    d.cnt = cnt_inc;
                    if (!q.is_read) begin
                        d.sh = {q.sh[14:0], q.dio_s2}; // RULE1
                    end
                    if (cnt_inc == mgmt_pkg::CNT_W'(mgmt_pkg::DATA_W)) begin
                        d.cnt   = '0;
                        d.state = S_IDLE;
                        d.oe    = 1'b0;
                        d.wr_en = ~q.is_read & q.match;
                    end
                end
            endcase
        end else if (fall && q.is_read && q.match) begin
            // Turnaround drives a zero, then data leaves top bit first
            if (q.state == S_TA && q.cnt == 6'h01) begin
                d.oe   = 1'b1;
                d.dout = 1'b0;
            end else if (q.state == S_DATA) begin
                d.dout = q.sh[15]; // RULE1
                d.sh   = {q.sh[14:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign mdio_out    = q.dout;
    assign mdio_oe     = q.oe;
    assign bus.rd_addr = q.addr;
    assign bus.wr_en   = q.wr_en;
    assign bus.wr_addr = q.addr;
    assign bus.wr_data = q.sh;

endmodule

// ### hdl/autoneg_id_register_bank.sv
/*
 * Management register bank of a 10/100 twisted-pair PHY: identifier low
 * word, advertisement, link partner ability and line configuration one,
 * reached over the serial management pins.
 * Assumes negotiation and line events arrive from logic on sys_clk.
 */
// Contract
// RULE1: Registers shift most significant bit first
// RULE2: Identifier low word read-only vendor/model/revision
// RULE3: Next-page flag writable, resets to zero
// RULE4: Software keeps next-page flag at zero
// RULE5: Acknowledge bit read-only, set on recognition
// RULE6: Remote fault bit writable, resets zero
// RULE7: Ability bits reset 0-1111, reserved writable zero
// RULE8: Selector bit writable, resets to one
// RULE9: Partner register read-only, resets to zero
// RULE10: Partner acknowledge bit read-only, reset zero
// RULE11: Partner remote fault read-only, reset zero
// RULE12: Line configuration one fully writable layout
// RULE13: Coder skip bit bypasses block coding
// RULE14: Scrambler skip bit bypasses scrambling
// RULE15: Link detect off forces link pass
// RULE16: Writes to read-only bits ignored
`timescale 1ns/1ps
module autoneg_id_register_bank #(
    parameter logic [4:0] PHY_ADDR      = 5'h00, // Device address on the port
    parameter logic [5:0] VENDOR_ID_BITS = 6'h15, // Arbitrary value
    parameter logic [5:0] MODEL_NUMBER  = 6'h2A, // Arbitrary value
    parameter logic [3:0] REVISION      = 4'h1   // Arbitrary value
) (
    input  wire logic        sys_clk,               // 200 MHz clock
    input  wire logic        rst,                   // Synchronous reset
    input  wire logic        mdc,                   // Management clock pin
    input  wire logic        mdio_in,               // Management data pin in
    output logic             mdio_out,              // Management data pin out
    output logic             mdio_oe,               // Management data drive enable
    input  wire logic        word_recognized,       // Partner word recognized
    input  wire logic        partner_valid,         // Partner word arrived
    input  wire logic [15:0] partner_word,          // Partner base page
    input  wire logic        link_detect_raw,       // Receive link detector
    output logic [15:0]      advertised_word,       // Base page to send
    output logic             link_pass,             // Link state after override
    output logic             link_detect_off,       // Link detection disabled
    output logic             transmitter_off,       // Transmitter disabled
    output logic             transmitter_powerdown, // Transmitter powered down
    output logic             tx_to_carrier_loop_off,// Loopback to carrier off
    output logic             block_coder_skip,      // Bypass block coder
    output logic             scrambler_skip,        // Bypass scrambler
    output logic             equalizer_select,      // Equalizer at zero length
    output logic             cable_type_stp,        // Shielded cable
    output logic             receive_level_adjust,  // Reduced squelch
    output logic [3:0]       transmit_level,        // Output level trim
    output logic [1:0]       edge_rate              // Rise/fall trim
);
    typedef struct packed {
        logic [15:0] adv;
        logic [15:0] partner;
        logic [15:0] cfg;
        logic        link_pass;
    } bank_state_t;

    localparam bank_state_t RESET_STATE = '{
        adv:       mgmt_pkg::ADV_RESET,     // RULE3 RULE6 RULE7 RULE8
        partner:   mgmt_pkg::PARTNER_RESET, // RULE9 RULE10 RULE11
        cfg:       mgmt_pkg::CFG_RESET,
        link_pass: 1'b0
    };

    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] mask);
        merge = (old_v & ~mask) | (new_v & mask);
    endfunction

    mgmt_if      bus ();
    bank_state_t q;
    bank_state_t d;

    mgmt_serial_port #(
        .PHY_ADDR (PHY_ADDR)
    ) u_port (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .mdc      (mdc),
        .mdio_in  (mdio_in),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe),
        .bus      (bus)
    );

    always_comb begin
        d = q;
        if (bus.wr_en) begin
            unique case (bus.wr_addr)
                mgmt_pkg::REG_ADVERTISE: begin
                    d.adv = merge(q.adv, bus.wr_data, mgmt_pkg::ADV_WR_MASK); // RULE3 RULE6 RULE7 RULE8 RULE16
                end
                mgmt_pkg::REG_LINE_CFG1: begin
                    d.cfg = merge(q.cfg, bus.wr_data, mgmt_pkg::CFG_WR_MASK); // RULE12
                end
                default: begin
                end
            endcase
        end
        d.adv[mgmt_pkg::ACK_BIT] = word_recognized; // RULE5 RULE16
        if (partner_valid) begin
            d.partner = partner_word & mgmt_pkg::PARTNER_MASK; // RULE9 RULE10 RULE11
        end
        d.link_pass = q.cfg[mgmt_pkg::CFG_LINK_OFF] | link_detect_raw; // RULE15
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        unique case (bus.rd_addr)
            mgmt_pkg::REG_ID_LOW: begin
                bus.rd_data = {VENDOR_ID_BITS, MODEL_NUMBER, REVISION}; // RULE2
            end
            mgmt_pkg::REG_ADVERTISE: begin
                bus.rd_data = q.adv;
            end
            mgmt_pkg::REG_PARTNER: begin
                bus.rd_data = q.partner; // RULE16
            end
            mgmt_pkg::REG_LINE_CFG1: begin
                bus.rd_data = q.cfg;
            end
            default: begin
                bus.rd_data = '0;
            end
        endcase
    end

    assign advertised_word        = q.adv;
    assign link_pass              = q.link_pass;
    assign link_detect_off        = q.cfg[mgmt_pkg::CFG_LINK_OFF];   // RULE15
    assign transmitter_off        = q.cfg[mgmt_pkg::CFG_TX_OFF];
    assign transmitter_powerdown  = q.cfg[mgmt_pkg::CFG_TX_PDN];
    assign tx_to_carrier_loop_off = q.cfg[mgmt_pkg::CFG_LOOP_OFF];
    assign block_coder_skip       = q.cfg[mgmt_pkg::CFG_CODER_SKIP]; // RULE13
    assign scrambler_skip         = q.cfg[mgmt_pkg::CFG_SCR_SKIP];   // RULE14
    assign equalizer_select       = q.cfg[mgmt_pkg::CFG_EQ_SEL];
    assign cable_type_stp         = q.cfg[mgmt_pkg::CFG_CABLE];
    assign receive_level_adjust   = q.cfg[mgmt_pkg::CFG_RX_LEVEL];
    assign transmit_level         = q.cfg[mgmt_pkg::CFG_TLVL_MSB:mgmt_pkg::CFG_TLVL_LSB];
    assign edge_rate              = q.cfg[mgmt_pkg::CFG_EDGE_MSB:0];

endmodule

// ### testbench/bank_checker_sva.sv
/* Concurrent checks on the register bank top-level ports.
   Assumes one sys_clk domain and the synchronous active-high rst. */
`timescale 1ns/1ps
module bank_checker (
    input wire logic        sys_clk,          // Clock
    input wire logic        rst,              // Reset
    input wire logic        mdc,              // Management clock
    input wire logic        mdio_out,         // Data drive value
    input wire logic        mdio_oe,          // Data drive enable
    input wire logic        word_recognized,  // Word recognized
    input wire logic        link_detect_raw,  // Raw link
    input wire logic [15:0] advertised_word,  // Advertisement
    input wire logic        link_pass,        // Link state
    input wire logic        link_detect_off,  // Link detect off
    input wire logic        block_coder_skip, // Coder bypass
    input wire logic        scrambler_skip,   // Scrambler bypass
    input wire logic [3:0]  transmit_level,   // Level trim
    input wire logic [1:0]  edge_rate         // Edge trim
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence ta_drive;
        mdio_oe && !mdio_out;
    endsequence
    sequence cfg_move;
        $changed({link_detect_off, block_coder_skip, scrambler_skip, transmit_level});
    endsequence
    AST_ADV_RESET: assert property ($fell(rst) |-> advertised_word == 16'h01E1)
        else $error("advertisement not at reset value");
    AST_CFG_RESET: assert property ($fell(rst) |-> transmit_level == 4'h8 &&
        edge_rate == 2'h2 && !link_pass && !mdio_oe)
        else $error("configuration outputs not at reset value");
    AST_ACK_SET: assert property (word_recognized |=> advertised_word[14])
        else $error("acknowledge bit not set");
    AST_ACK_CLEAR: assert property (!word_recognized |=> !advertised_word[14])
        else $error("acknowledge bit set without recognition");
    AST_LINK_FORCE: assert property (link_detect_off |=> link_pass)
        else $error("link pass not forced");
    AST_LINK_FOLLOW: assert property (!link_detect_off && !link_detect_raw |=> !link_pass)
        else $error("link pass without link");
    AST_TA_ZERO: assert property ($rose(mdio_oe) |-> ta_drive [*8])
        else $error("turnaround not driven low");
    AST_OUT_LOW_HALF: assert property (mdio_oe && $changed(mdio_out) |-> !mdc)
        else $error("read data changed while mdc high");
    AST_CFG_QUIET: assert property (cfg_move |-> !mdio_oe)
        else $error("configuration changed during read");
    AST_ADV_QUIET: assert property ($changed(advertised_word & 16'hBFFF) |-> !mdio_oe)
        else $error("advertisement changed during read");
endmodule

bind autoneg_id_register_bank bank_checker chk_u (
    .sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .word_recognized(word_recognized), .link_detect_raw(link_detect_raw),
    .advertised_word(advertised_word), .link_pass(link_pass),
    .link_detect_off(link_detect_off), .block_coder_skip(block_coder_skip),
    .scrambler_skip(scrambler_skip), .transmit_level(transmit_level), .edge_rate(edge_rate)
);

// ### testbench/mgmt_host.sv
/* Station management controller model: frames on mdc and mdio.
   Assumes the bench resolves mdio with a pull-up; mdc stands low when idle. */
`timescale 1ns/1ps
module mgmt_host (
    input  wire logic sys_clk,  // System clock
    input  wire logic mdio,     // Resolved data line
    output logic      mdc,      // Management clock
    output logic      host_out, // Drive value
    output logic      host_oe   // Drive enable
);
    initial begin
        mdc = 1'b0;
        host_out = 1'b1;
        host_oe = 1'b0;
    end
    // Half period of 10 sys_clk; released for turnaround and data on reads
    task automatic xfer(input logic [1:0] op, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] fr;
        fr = {32'hFFFFFFFF, 2'h1, op, 5'h00, ra, 2'h2, wd};
        rd = 16'h0000;
        for (int i = 63; i >= 0; i--) begin
            host_oe  <= !(op == mgmt_pkg::OP_READ && i < 18);
            host_out <= fr[i];
            repeat (10) @(posedge sys_clk);
            mdc <= 1'b1;
            if (i < 16)
                rd[i] = mdio;
            repeat (10) @(posedge sys_clk);
            mdc <= 1'b0;
        end
        host_oe <= 1'b0;
        repeat (10) @(posedge sys_clk);
    endtask
endmodule

// ### testbench/autoneg_id_register_bank_tb.sv
/* Self-checking bench for the register bank through its management pins.
   Assumes the host model drives frames and mdio has a pull-up. */
`timescale 1ns/1ps
module autoneg_id_register_bank_tb;
    localparam logic [5:0]  VID = 6'h2C; // Arbitrary value
    localparam logic [5:0]  MOD = 6'h13; // Arbitrary value
    localparam logic [3:0]  REV = 4'h9;  // Arbitrary value
    localparam logic [15:0] ID_EXP = {VID, MOD, REV};
    logic sys_clk, rst, word_recognized, partner_valid, link_detect_raw;
    logic [15:0] partner_word, advertised_word;
    logic mdc, mdio, mdio_out, mdio_oe, host_out, host_oe, link_pass;
    logic link_detect_off, transmitter_off, transmitter_powerdown, tx_to_carrier_loop_off;
    logic block_coder_skip, scrambler_skip, equalizer_select, cable_type_stp;
    logic receive_level_adjust;
    logic [3:0] transmit_level;
    logic [1:0] edge_rate;
    int bad_count, checks_done;
    assign mdio = mdio_oe ? mdio_out : (host_oe ? host_out : 1'b1);
    autoneg_id_register_bank #(.VENDOR_ID_BITS(VID), .MODEL_NUMBER(MOD), .REVISION(REV)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdio_in(mdio), .mdio_out(mdio_out),
        .mdio_oe(mdio_oe), .word_recognized(word_recognized), .partner_valid(partner_valid),
        .partner_word(partner_word), .link_detect_raw(link_detect_raw),
        .advertised_word(advertised_word), .link_pass(link_pass),
        .link_detect_off(link_detect_off), .transmitter_off(transmitter_off),
        .transmitter_powerdown(transmitter_powerdown),
        .tx_to_carrier_loop_off(tx_to_carrier_loop_off), .block_coder_skip(block_coder_skip),
        .scrambler_skip(scrambler_skip), .equalizer_select(equalizer_select),
        .cable_type_stp(cable_type_stp), .receive_level_adjust(receive_level_adjust),
        .transmit_level(transmit_level), .edge_rate(edge_rate));
    mgmt_host host_u (.sys_clk(sys_clk), .mdio(mdio), .mdc(mdc), .host_out(host_out),
                      .host_oe(host_oe));
    always #2.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [4:0] ra, output logic [15:0] v);
        host_u.xfer(mgmt_pkg::OP_READ, ra, 16'h0000, v);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] v;
        host_u.xfer(mgmt_pkg::OP_WRITE, ra, d, v);
    endtask
    task automatic reset_values;
        logic [15:0] v;
        rd(mgmt_pkg::REG_ID_LOW, v);
        chk(v, ID_EXP);
        rd(mgmt_pkg::REG_ADVERTISE, v);
        chk(v, 16'h01E1);
        rd(mgmt_pkg::REG_PARTNER, v);
        chk(v, 16'h0000);
        rd(mgmt_pkg::REG_LINE_CFG1, v);
        chk(v, 16'h0022);
    endtask
    task automatic adv_writes;
        logic [15:0] v;
        wr(mgmt_pkg::REG_ADVERTISE, 16'hFFFF);
        rd(mgmt_pkg::REG_ADVERTISE, v);
        chk(v, 16'hBFFF);
        chk(advertised_word, 16'hBFFF);
        wr(mgmt_pkg::REG_ADVERTISE, 16'h0000);
        rd(mgmt_pkg::REG_ADVERTISE, v);
        chk(v, 16'h0000);
        word_recognized <= 1'b1;
        rd(mgmt_pkg::REG_ADVERTISE, v);
        chk(v, 16'h4000);
        word_recognized <= 1'b0;
    endtask
    task automatic ro_writes;
        logic [15:0] v;
        wr(mgmt_pkg::REG_ID_LOW, 16'hFFFF);
        wr(mgmt_pkg::REG_PARTNER, 16'hFFFF);
        wr(5'h1F, 16'hFFFF);
        // Illegal opcode: frame must be dropped without a write
        host_u.xfer(2'h3, mgmt_pkg::REG_LINE_CFG1, 16'hFFFF, v);
        rd(mgmt_pkg::REG_LINE_CFG1, v);
        chk(v, 16'h0022);
        rd(mgmt_pkg::REG_ID_LOW, v);
        chk(v, ID_EXP);
        rd(mgmt_pkg::REG_PARTNER, v);
        chk(v, 16'h0000);
        rd(5'h1F, v);
        chk(v, 16'h0000);
    endtask
    task automatic partner_event(input logic [15:0] w, input logic [15:0] exp);
        logic [15:0] v;
        partner_word <= w;
        partner_valid <= 1'b1;
        @(posedge sys_clk);
        partner_valid <= 1'b0;
        rd(mgmt_pkg::REG_PARTNER, v);
        chk(v, exp);
    endtask
    task automatic cfg_writes(input logic [15:0] p);
        logic [15:0] v;
        wr(mgmt_pkg::REG_LINE_CFG1, p);
        rd(mgmt_pkg::REG_LINE_CFG1, v);
        chk(v, p);
        chk({link_detect_off, transmitter_off, transmitter_powerdown, tx_to_carrier_loop_off,
             block_coder_skip, scrambler_skip, p[9], equalizer_select, cable_type_stp,
             receive_level_adjust, transmit_level, edge_rate}, p);
        link_detect_raw <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({15'h0000, link_pass}, {15'h0000, p[15]});
        link_detect_raw <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({15'h0000, link_pass}, 16'h0001);
    endtask
    // Reset in mid-run: every register returns to its reset value
    task automatic mid_reset;
        rst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        reset_values;
        chk({15'h0000, link_pass}, 16'h0001);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        word_recognized = 1'b0;
        partner_valid = 1'b0;
        partner_word = 16'h0000;
        link_detect_raw = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        reset_values;
        adv_writes;
        ro_writes;
        partner_event(16'hFFFF, 16'hE3E1);
        partner_event(16'h4000, 16'h4000);
        partner_event(16'h2000, 16'h2000);
        cfg_writes(16'hA5A5);
        cfg_writes(16'h5A5A);
        cfg_writes(16'h0000);
        mid_reset;
        test_done;
    end
    // About 30 frames of 1300 cycles each, with margin
    initial begin
        #400000;
        bad_count++;
        test_done;
    end
endmodule
